// ### core/multicast_capability_regs.vh
// Register map, field positions and reset values of the multicast capability block.
// Assumes inclusion by the block that decodes configuration accesses over AHB-Lite.
`ifndef MULTICAST_CAPABILITY_REGS_VH
`define MULTICAST_CAPABILITY_REGS_VH

// ---------------------------------------------------------------------------
// Printed register indices; byte address is four times the index.
// ---------------------------------------------------------------------------
`define MC_CAPABILITY_IDX    12'h334
`define MC_CONTROL_IDX       12'h336
`define MC_BASE_LOW_IDX      12'h338
`define MC_BASE_HIGH_IDX     12'h33C
`define MC_CONFIG_LOCK_IDX   12'h33E

// ---------------------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------------------
`define MC_COUNT_MSB         5
`define MC_COUNT_LSB         0
`define MC_FLAG_BIT          15
`define MC_BASE_LOW_LSB      12
`define MC_MIN_INDEX_POS     6'h0C

// ---------------------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------------------
`define MC_SUPPORTED_RST     6'h1F
`define MC_ECRC_RST          1'h1
`define MC_ENABLED_RST       6'h00
`define MC_ON_RST            1'h0
`define MC_INDEX_POS_RST     6'h00
`define MC_BASE_LOW_RST      20'h00000
`define MC_BASE_HIGH_RST     32'h00000000

`endif

// ### core/multicast_capability.v
// Multicast capability register bank of one switch port bridge, with group decode.
// Assumes a single AHB-Lite master issuing whole-word single transfers and a
// TLP address presented synchronous to hclk for group classification.
`timescale 1ns/100ps
`include "multicast_capability_regs.vh"

module multicast_capability #(
  parameter ADDR_W = 14
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire              hready,
  input  wire [31:0]       hwdata,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  // TLP classification
  input  wire              tlp_valid,
  input  wire [63:0]       tlp_addr,
  output reg               group_hit,
  output reg  [5:0]        group_number,
  output reg               group_active,
  // Settings seen by the forwarding logic
  output reg               multicast_on,
  output reg  [6:0]        supported_groups,
  output reg  [6:0]        active_groups
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_CAP  = 3'h1;
  localparam [2:0] SEL_CTL  = 3'h2;
  localparam [2:0] SEL_BLO  = 3'h3;
  localparam [2:0] SEL_BHI  = 3'h4;
  localparam [2:0] SEL_LOCK = 3'h5;

  // Word-aligned addresses only; byte offsets 1..3 fall into the unmapped set.
  function [2:0] decode;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0) begin
        decode = SEL_NONE;
      end else begin
        case (a[ADDR_W-1:2])
          `MC_CAPABILITY_IDX:  decode = SEL_CAP;
          `MC_CONTROL_IDX:     decode = SEL_CTL;
          `MC_BASE_LOW_IDX:    decode = SEL_BLO;
          `MC_BASE_HIGH_IDX:   decode = SEL_BHI;
          `MC_CONFIG_LOCK_IDX: decode = SEL_LOCK;
          default:             decode = SEL_NONE;
        endcase
      end
    end
  endfunction

  // Capability and control share one layout: flag in bit 15, count in 5:0,
  // and every other bit reserved and read as zero.
  function [31:0] pack_short;
    input       flag;
    input [5:0] count;
    begin
      pack_short = {16'h0000, flag, 9'h000, count};
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  reg  [5:0]  supported_group_count_reg;
  reg         ecrc_regen_supported_reg;
  reg  [5:0]  enabled_group_count_reg;
  reg         multicast_on_reg;
  reg  [5:0]  group_index_position_reg;
  reg  [19:0] multicast_base_lower_bits_reg;
  reg  [31:0] multicast_base_upper_bits_reg;
  reg         config_lock_reg;

  reg  [5:0]  supported_group_count_next;
  reg         ecrc_regen_supported_next;
  reg  [5:0]  enabled_group_count_next;
  reg         multicast_on_next;
  reg  [5:0]  group_index_position_next;
  reg  [19:0] multicast_base_lower_bits_next;
  reg  [31:0] multicast_base_upper_bits_next;
  reg         config_lock_next;

  // The lock bit closes the initial-configuration window of the capability
  // fields; only a reset opens it again.

  // Data-phase bookkeeping.
  reg         wr_pend_reg;
  reg  [2:0]  wr_sel_reg;

  wire        take = hsel & hready & htrans[1];
  wire [2:0]  addr_sel = decode(haddr);
  wire        rd_take  = take & ~hwrite;
  wire        wr_take  = take & hwrite;

  // Byte lanes are not decoded: every access counts as a whole word, so hsize
  // is left unread and a narrow write replaces the full register.

  // ---------------------------------------------------------------------------
  // Register write path
  // ---------------------------------------------------------------------------
  // Reserved bits are simply not stored, so writes to them are lost and reads
  // rebuild them as zero.
  always @* begin
    supported_group_count_next     = supported_group_count_reg;
    ecrc_regen_supported_next      = ecrc_regen_supported_reg;
    enabled_group_count_next       = enabled_group_count_reg;
    multicast_on_next              = multicast_on_reg;
    group_index_position_next      = group_index_position_reg;
    multicast_base_lower_bits_next = multicast_base_lower_bits_reg;
    multicast_base_upper_bits_next = multicast_base_upper_bits_reg;
    config_lock_next               = config_lock_reg;
    if (wr_pend_reg) begin
      case (wr_sel_reg)
        SEL_CAP: begin
          // Initial-configuration load only; after lock the fields stand still.
          if (!config_lock_reg) begin
            supported_group_count_next = hwdata[`MC_COUNT_MSB:`MC_COUNT_LSB];
            ecrc_regen_supported_next  = hwdata[`MC_FLAG_BIT];
          end
        end
        SEL_CTL: begin
          enabled_group_count_next = hwdata[`MC_COUNT_MSB:`MC_COUNT_LSB];
          multicast_on_next        = hwdata[`MC_FLAG_BIT];
        end
        SEL_BLO: begin
          group_index_position_next      = hwdata[`MC_COUNT_MSB:`MC_COUNT_LSB];
          multicast_base_lower_bits_next = hwdata[31:`MC_BASE_LOW_LSB];
        end
        SEL_BHI: begin
          multicast_base_upper_bits_next = hwdata;
        end
        SEL_LOCK: begin
          // Lock is sticky until reset, ending the initial-configuration window.
          config_lock_next = config_lock_reg | hwdata[0];
        end
        default: begin
          config_lock_next = config_lock_reg;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supported_group_count_reg     <= `MC_SUPPORTED_RST;
      ecrc_regen_supported_reg      <= `MC_ECRC_RST;
      enabled_group_count_reg       <= `MC_ENABLED_RST;
      multicast_on_reg              <= `MC_ON_RST;
      group_index_position_reg      <= `MC_INDEX_POS_RST;
      multicast_base_lower_bits_reg <= `MC_BASE_LOW_RST;
      multicast_base_upper_bits_reg <= `MC_BASE_HIGH_RST;
      config_lock_reg               <= 1'h0;
      wr_pend_reg                   <= 1'h0;
      wr_sel_reg                    <= SEL_NONE;
    end else begin
      supported_group_count_reg     <= supported_group_count_next;
      ecrc_regen_supported_reg      <= ecrc_regen_supported_next;
      enabled_group_count_reg       <= enabled_group_count_next;
      multicast_on_reg              <= multicast_on_next;
      group_index_position_reg      <= group_index_position_next;
      multicast_base_lower_bits_reg <= multicast_base_lower_bits_next;
      multicast_base_upper_bits_reg <= multicast_base_upper_bits_next;
      config_lock_reg               <= config_lock_next;
      wr_pend_reg                   <= wr_take;
      wr_sel_reg                    <= addr_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Read data is built from the next values so that a read right behind a
  // write returns the new contents with no wait state.
  reg [31:0] rd_next;

  always @* begin
    rd_next = 32'h00000000;
    case (addr_sel)
      SEL_CAP: begin
        rd_next = pack_short(ecrc_regen_supported_next, supported_group_count_next);
      end
      SEL_CTL: begin
        rd_next = pack_short(multicast_on_next, enabled_group_count_next);
      end
      SEL_BLO: begin
        rd_next = {multicast_base_lower_bits_next, 6'h00, group_index_position_next};
      end
      SEL_BHI: begin
        rd_next = multicast_base_upper_bits_next;
      end
      SEL_LOCK: begin
        rd_next = {{31{1'b0}}, config_lock_next};
      end
      default: begin
        rd_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end else begin
      // Zero wait states: every data phase completes in one cycle and an
      // error response is never returned.
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
      if (rd_take) begin
        hrdata <= rd_next;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Group classification
  // ---------------------------------------------------------------------------
  // Software guarantees index position of 12 or more and zeroed base bits over
  // the group field; outside that the result is undefined, so no guard here.
  wire [63:0] base_full  = {multicast_base_upper_bits_reg,
                            multicast_base_lower_bits_reg, 12'h000};
  wire [63:0] addr_shift = tlp_addr >> group_index_position_reg;
  wire [5:0]  grp        = addr_shift[5:0];
  wire [63:0] top_mask   = {64{1'b1}} << group_index_position_reg;
  wire [63:0] hi_mask    = top_mask << 6;
  wire [63:0] bit_ok;

  // Each address bit above the group field must agree with the base; bits in
  // the group field take part only through the group number, and bits below it are ignored.
  genvar i;
  generate
    for (i = 0; i < 64; i = i + 1) begin : g_base_bit
      assign bit_ok[i] = ~hi_mask[i] | ~(tlp_addr[i] ^ base_full[i]);
    end
  endgenerate

  wire        base_match = &bit_ok;
  wire        tlp_hit    = tlp_valid & multicast_on_reg & base_match;
  wire        in_range   = (grp <= enabled_group_count_reg);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      group_hit        <= 1'h0;
      group_number     <= 6'h00;
      group_active     <= 1'h0;
    end else begin
      group_hit        <= tlp_hit;
      group_number     <= grp;
      group_active     <= tlp_hit & in_range;
    end
  end

  // ---------------------------------------------------------------------------
  // Settings seen by the forwarding logic
  // ---------------------------------------------------------------------------
  // These copies trail the register bits by one cycle; all of them change on
  // the same edge, so the forwarding logic never sees a mixed pair.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multicast_on     <= 1'h0;
      supported_groups <= 7'h00;
      active_groups    <= 7'h00;
    end else begin
      multicast_on     <= multicast_on_reg;
      supported_groups <= {1'b0, supported_group_count_reg} + 7'h01;
      if (multicast_on_reg) begin
        active_groups  <= {1'b0, enabled_group_count_reg} + 7'h01;
      end else begin
        active_groups  <= 7'h00;
      end
    end
  end

endmodule // multicast_capability

// ### tb/multicast_capability_asserts.sv
// Concurrent checks on the multicast register bank ports.
// Assumes a zero-wait-state bus and settings held steady while TLPs flow.
`timescale 1ns/100ps
module multicast_capability_asserts #(
  parameter ADDR_W = 14
) (
  // Clock, reset and bus
  input wire              hclk,
  input wire              hresetn,
  input wire              hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire              hready,
  input wire [31:0]       hwdata,
  input wire [31:0]       hrdata,
  input wire              hreadyout,
  input wire              hresp,
  // Classification and settings
  input wire              group_hit,
  input wire [5:0]        group_number,
  input wire              group_active,
  input wire              multicast_on,
  input wire [6:0]        active_groups,
  input wire [6:0]        supported_groups
);
  wire rd_t = hsel & hready & htrans[1] & ~hwrite;
  wire wr_t = hsel & hready & htrans[1] & hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready okay");
  a_read_hold: assert property (!rd_t |=> $stable(hrdata)) else $error("read data moved");
  a_short_reserved: assert property (rd_t && (haddr == 14'h0CD0 || haddr == 14'h0CD8)
    |=> hrdata[31:16] == 16'h0000 && hrdata[14:6] == 9'h000) else $error("reserved set");
  a_base_reserved: assert property (rd_t && haddr == 14'h0CE0
    |=> hrdata[11:6] == 6'h00) else $error("base reserved set");
  a_unmapped_zero: assert property (rd_t && !(haddr inside {14'h0CD0, 14'h0CD8, 14'h0CE0,
    14'h0CF0, 14'h0CF8}) |=> hrdata == 32'h00000000) else $error("unmapped read not zero");
  a_group_count: assert property (rd_t && haddr == 14'h0CD0
    |-> ##2 supported_groups == {1'b0, $past(hrdata[5:0])} + 7'h01) else $error("count");
  a_on_follows: assert property (wr_t && haddr == 14'h0CD8
    |-> ##3 multicast_on == $past(hwdata[15], 2)) else $error("enable not taken");
  a_off_inactive: assert property (!multicast_on |-> active_groups == 7'h00)
    else $error("groups active while off");
  a_active_hit: assert property (group_active |->
    group_hit && group_number < active_groups) else $error("active group out of range");
endmodule // multicast_capability_asserts

bind multicast_capability multicast_capability_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .group_hit(group_hit),
  .group_number(group_number), .group_active(group_active), .multicast_on(multicast_on),
  .active_groups(active_groups), .supported_groups(supported_groups));

// ### tb/tb_top.sv
// Self-checking bench for the multicast register bank.
// Assumes the checker is bound to the block; the bench is the only bus master.
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [13:0] haddr = 14'h0000;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         tlp_valid = 1'b0;
  reg  [63:0] tlp_addr = 64'h0;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, group_hit, group_active, multicast_on;
  wire [5:0]  group_number;
  wire [6:0]  supported_groups, active_groups;
  int         errors = 0;
  int         comparisons = 0;
  always #2.5 hclk = ~hclk;
  multicast_capability dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tlp_valid(tlp_valid), .tlp_addr(tlp_addr),
    .group_hit(group_hit), .group_number(group_number), .group_active(group_active),
    .multicast_on(multicast_on), .supported_groups(supported_groups),
    .active_groups(active_groups));
  task bus(input bit w, input [13:0] a, input [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input [13:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task chk_rd(input [13:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // The address is inverted after its cycle so a stale value cannot pass.
  task tlp(input [63:0] a, input h, input [5:0] n, input act);
    @(posedge hclk);
    tlp_valid <= 1'b1;
    tlp_addr  <= a;
    @(posedge hclk);
    tlp_valid <= 1'b0;
    tlp_addr  <= ~a;
    #1;
    `CHK({group_hit, group_number, group_active}, {h, n, act})
  endtask
  task final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(14'h0CD0, 32'h0000801F);
    chk_rd(14'h0CD8, 32'h00000000);
    chk_rd(14'h0CE0, 32'h00000000);
    chk_rd(14'h0CF0, 32'h00000000);
    chk_rd(14'h0CD4, 32'h00000000);
    chk_rd(14'h0CF8, 32'h00000000);
    `CHK(supported_groups, 7'h20)
    $display("test reset values done");
    wr(14'h0CD0, 32'hFFFFFFFF);
    chk_rd(14'h0CD0, 32'h0000803F);
    wr(14'h0CD0, 32'h0000003F);
    chk_rd(14'h0CD0, 32'h0000003F);
    wr(14'h0CD0, 32'h0000803F);
    wr(14'h0CF8, 32'h00000001);
    chk_rd(14'h0CF8, 32'h00000001);
    wr(14'h0CD0, 32'h00000000);
    chk_rd(14'h0CD0, 32'h0000803F);
    `CHK(supported_groups, 7'h40)
    $display("test capability lock done");
    // Base fields are exercised while multicast is still off.
    wr(14'h0CE0, 32'hFFFFFFFF);
    chk_rd(14'h0CE0, 32'hFFFFF03F);
    wr(14'h0CF0, 32'hA5A55A5A);
    chk_rd(14'h0CF0, 32'hA5A55A5A);
    wr(14'h0CD4, 32'hFFFFFFFF);
    chk_rd(14'h0CD4, 32'h00000000);
    wr(14'h0CE0, 32'h00C00010);
    wr(14'h0CF0, 32'h00000001);
    wr(14'h0CD8, 32'hFFFFFFFF);
    chk_rd(14'h0CD8, 32'h0000803F);
    `CHK({multicast_on, active_groups}, {1'b1, 7'h40})
    $display("test register access done");
    wr(14'h0CD8, 32'h00008007);
    chk_rd(14'h0CD8, 32'h00008007);
    `CHK(active_groups, 7'h08)
    tlp({32'h1, 32'h00C50000}, 1'b1, 6'h05, 1'b1);
    tlp({32'h1, 32'h00C70000}, 1'b1, 6'h07, 1'b1);
    tlp({32'h1, 32'h00CA0000}, 1'b1, 6'h0A, 1'b0);
    tlp({32'h2, 32'h00C50000}, 1'b0, 6'h05, 1'b0);
    tlp({32'h1, 32'h00870000}, 1'b0, 6'h07, 1'b0);
    wr(14'h0CD8, 32'h00000007);
    chk_rd(14'h0CD8, 32'h00000007);
    `CHK({multicast_on, active_groups}, {1'b0, 7'h00})
    tlp({32'h1, 32'h00C50000}, 1'b0, 6'h05, 1'b0);
    $display("test classification done");
    // A second reset must reopen the capability window and restore the lock, supported count, base low, index position and enable bit to their reset values.
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(14'h0CF8, 32'h00000000);
    `CHK(supported_groups, 7'h20)
    chk_rd(14'h0CE0, 32'h00000000);
    wr(14'h0CD0, 32'h0000003F);
    chk_rd(14'h0CD0, 32'h0000003F);
    `CHK({multicast_on, supported_groups}, {1'b0, 7'h40})
    $display("test second reset done");
    final_report;
  end
endmodule // tb_top
